// >>> fdc_glue_pkg.sv
// constants for the floppy interface glue logic
// assumes a 250 MHz system clock and 8-bit port i/o from the cpu side
package fdc_glue_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REF_MHZ = 4;
  localparam int unsigned REF_DIV = CLK_MHZ / (2 * REF_MHZ);
  localparam int unsigned MOTOR_ON_MS = 3000;
  localparam int unsigned MOTOR_ON_CYCLES = MOTOR_ON_MS * 1000 * CLK_MHZ;
  localparam int unsigned STRETCH_NS = 500;
  localparam int unsigned STRETCH_CYCLES = (STRETCH_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] PORT_IRQ = 8'he4;
  localparam logic [7:0] PORT_CMD_STATUS = 8'hf0;
  localparam logic [7:0] PORT_TRACK = 8'hf1;
  localparam logic [7:0] PORT_SECTOR = 8'hf2;
  localparam logic [7:0] PORT_DATA = 8'hf3;
  localparam logic [7:0] PORT_DRIVE_SEL = 8'hf4;
  localparam int unsigned BIT_DONE_EN = 7;
  localparam int unsigned BIT_MOTOR_EN = 6;
  localparam int unsigned BIT_RESET_ST = 5;
  localparam int unsigned BIT_SIDE = 4;
  localparam int unsigned BIT_PRECOMP = 5;
  localparam int unsigned BIT_LONG_WAIT = 6;
  localparam int unsigned BIT_DENSITY = 7;
  localparam int unsigned WDOG_WIDTH = 12;
  localparam int unsigned WDOG_EXPIRE_BIT = 10;
  localparam logic [11:0] WDOG_SHORT = 12'h002;
  localparam logic [2:0] PRECOMP_EARLY = 3'h1;
  localparam logic [2:0] PRECOMP_NOMINAL = 3'h2;
  localparam logic [2:0] PRECOMP_LATE = 3'h4;
  // idle pin levels: strobes and early/late high, requests and write pulse low
  localparam logic [7:0] PIN_IDLE = 8'he3;
endpackage

// >>> fdc_ref_clock.sv
// reference clock divider: 4, 2 and 1 MHz phases, with clock-enable ticks for 4 and 1 MHz only
// assumes ref_clk_in at 250 MHz; outputs are levels plus rising-edge ticks
`timescale 1ns/1ps
`default_nettype none
module fdc_ref_clock
  import fdc_glue_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  output logic clk4_out,
  output logic clk2_out,
  output logic clk1_out,
  output logic tick4_out,
  output logic tick1_out
);
  logic [7:0] div_cnt;
  logic [2:0] phase;
  logic clk1_q;
  wire half = (div_cnt == 8'(REF_DIV - 1));
  wire [2:0] next_phase = phase + 3'h1;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      div_cnt <= 8'h00;
      phase <= 3'h0;
      clk1_q <= 1'b0;
    end else begin
      div_cnt <= half ? 8'h00 : div_cnt + 8'h01;
      if (half) phase <= next_phase;
      if (half) clk1_q <= next_phase[2] ^ next_phase[1];
    end
  end

  // 1 MHz rises and falls on 2 MHz rising edges
  assign clk4_out = phase[0];
  assign clk2_out = phase[1];
  // registered: two phase bits flip together, a bare xor could glitch the clock
  assign clk1_out = clk1_q;
  assign tick4_out = half && !phase[0];
  assign tick1_out = half && (phase == 3'h1);
endmodule
`default_nettype wire

// >>> fdc_glue.sv
// floppy glue: irq mask/status, drive select, motor timer, cpu wait, precomp
// assumes cpu strobes are active-low pins; controller chip is outside
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - mask bit 7 gates controller done onto nmi
// RQ2 - mask bit 6 gates motor timeout onto nmi
// RQ3 - status bits 7,6 report done, timeout, low-true
// RQ4 - status bit 5 reset; drive bus during strobe
// RQ5 - d0-d3 latch drive selects, software one-hot
// RQ6 - d4 selects disk side
// RQ7 - d5 latches precompensation enable
// RQ8 - d6 set raises wait latch
// RQ9 - d7 selects double density
// RQ10 - each select write retriggers three-second motor
// RQ11 - motor expiry clears drive select latch
// RQ12 - requests, reset, short clear, watchdog release wait
// RQ13 - 1 MHz watchdog caps wait at 1024 us
// RQ14 - d6 clear still stalls until count two
// RQ15 - derive 2 and 1 MHz from 4 MHz
// RQ16 - precomp shift register, 250/500/750 ns delays
// RQ17 - precomp only when enabled and double density
// RQ18 - gate write pulse with 2 MHz, stretch 500 ns
// RQ19 - separator divisor follows density select
// RQ20 - controller registers decode at consecutive ports
// RQ21 - software waits before each double density byte
// RQ22 - watchdog held clear while no wait
module fdc_glue
  import fdc_glue_pkg::*;
#(
  parameter int unsigned MOTOR_CYCLES = MOTOR_ON_CYCLES
)(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] cpu_addr_in,
  input wire logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe_out,
  input wire logic irq_mask_write_strobe_n_in,
  input wire logic irq_status_read_strobe_n_in,
  input wire logic select_latch_write_strobe_n_in,
  input wire logic controller_done_request_in,
  input wire logic controller_byte_request_in,
  input wire logic controller_write_pulse_in,
  input wire logic precomp_early_n_in,
  input wire logic precomp_late_n_in,
  output logic nmi_n_out,
  output logic cpu_wait_n_out,
  output logic [3:0] drive_select_out,
  output logic side_select_out,
  output logic motor_on_out,
  output logic double_density_select_out,
  output logic double_density_select_n_out,
  output logic separator_divisor_select_out,
  output logic separator_reference_clock_out,
  output logic controller_clock_out,
  output logic write_pulse_out,
  output logic [3:0] controller_reg_select_out
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] meta;
  logic [7:0] sync;
  wire [7:0] pins = {irq_mask_write_strobe_n_in, irq_status_read_strobe_n_in,
    select_latch_write_strobe_n_in, controller_done_request_in,
    controller_byte_request_in, controller_write_pulse_in,
    precomp_early_n_in, precomp_late_n_in};
  logic [7:0] data_q1;
  logic [7:0] data_q2;
  logic mask_wr_prev;
  logic sel_wr_prev;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      // idle levels, so no false edge follows reset
      meta <= PIN_IDLE;
      sync <= PIN_IDLE;
      data_q1 <= 8'h00;
      data_q2 <= 8'h00;
      mask_wr_prev <= 1'b1;
      sel_wr_prev <= 1'b1;
    end else begin
      meta <= pins;
      sync <= meta;
      data_q1 <= cpu_data_in;
      data_q2 <= data_q1;
      mask_wr_prev <= sync[7];
      sel_wr_prev <= sync[5];
    end
  end

  wire status_rd_n = sync[6];
  wire done_req = sync[4];
  wire byte_req = sync[3];
  wire wr_pulse = sync[2];
  wire early_n = sync[1];
  wire late_n = sync[0];
  // latches take data on the strobe's rising (trailing) edge
  wire mask_wr = sync[7] && !mask_wr_prev;
  wire sel_wr = sync[5] && !sel_wr_prev;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  logic clk4;
  logic clk2;
  logic clk1;
  logic tick4;
  logic tick1;

  fdc_ref_clock fdc_ref_clock_inst (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .clk4_out(clk4),
    .clk2_out(clk2),
    .clk1_out(clk1),
    .tick4_out(tick4),
    .tick1_out(tick1)
  ); // RQ15

  // ---------------------------------------------------------------
  // nmi mask and status
  // ---------------------------------------------------------------
  logic done_en;
  logic motor_en;
  logic motor_timeout;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      done_en <= 1'b0;
      motor_en <= 1'b0;
    end else if (mask_wr) begin
      done_en <= data_q2[BIT_DONE_EN]; // RQ1
      motor_en <= data_q2[BIT_MOTOR_EN]; // RQ2
    end
  end

  wire nmi = (done_en && done_req) || (motor_en && motor_timeout); // RQ1 RQ2
  wire [7:0] status_word = {!done_req, !motor_timeout, 1'b1, 5'h1f}; // RQ3 RQ4

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      nmi_n_out <= 1'b1;
      cpu_data_out <= 8'hff;
      cpu_data_oe_out <= 1'b0;
    end else begin
      nmi_n_out <= !nmi;
      cpu_data_out <= status_word; // RQ3
      cpu_data_oe_out <= !status_rd_n; // RQ4
    end
  end

  // ---------------------------------------------------------------
  // drive select latch and motor timer
  // ---------------------------------------------------------------
  logic [31:0] motor_cnt;
  logic precomp_en;
  wire motor_on = (motor_cnt != 32'h0);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      motor_cnt <= 32'h0;
      motor_timeout <= 1'b0;
    end else if (sel_wr) begin
      motor_cnt <= 32'(MOTOR_CYCLES); // RQ10
      motor_timeout <= 1'b0;
    end else if (motor_on) begin
      motor_cnt <= motor_cnt - 32'h1;
      if (motor_cnt == 32'h1) motor_timeout <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      drive_select_out <= 4'h0;
      side_select_out <= 1'b0;
      precomp_en <= 1'b0;
      double_density_select_out <= 1'b0;
    end else if (sel_wr) begin
      drive_select_out <= data_q2[3:0]; // RQ5
      side_select_out <= data_q2[BIT_SIDE]; // RQ6
      precomp_en <= data_q2[BIT_PRECOMP]; // RQ7
      double_density_select_out <= data_q2[BIT_DENSITY]; // RQ9
    end else if (!motor_on) begin
      drive_select_out <= 4'h0; // RQ11
      side_select_out <= 1'b0;
      precomp_en <= 1'b0;
      double_density_select_out <= 1'b0;
    end
  end

  assign motor_on_out = motor_on;
  assign double_density_select_n_out = !double_density_select_out;
  assign separator_divisor_select_out = !double_density_select_out; // RQ19
  assign separator_reference_clock_out = clk4;
  assign controller_clock_out = clk1; // RQ15

  // ---------------------------------------------------------------
  // cpu wait and watchdog
  // ---------------------------------------------------------------
  logic wait_latch;
  logic long_wait;
  logic [WDOG_WIDTH-1:0] wdog;
  wire stall_watchdog_expiry = wdog[WDOG_EXPIRE_BIT]; // RQ13
  wire short_stall_clear = !long_wait && (wdog == WDOG_SHORT); // RQ14
  wire controller_request_any = done_req || byte_req; // RQ21
  wire wait_clear = controller_request_any || short_stall_clear || stall_watchdog_expiry;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wait_latch <= 1'b0; // RQ12
      long_wait <= 1'b0;
    end else if (sel_wr) begin
      wait_latch <= 1'b1; // RQ8 RQ14
      long_wait <= data_q2[BIT_LONG_WAIT];
    end else if (wait_clear) begin
      wait_latch <= 1'b0; // RQ12
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || !wait_latch) wdog <= '0; // RQ22
    else if (tick1) wdog <= wdog + 1'b1; // RQ13
  end

  assign cpu_wait_n_out = !wait_latch;

  // ---------------------------------------------------------------
  // write precompensation and pulse shaping
  // ---------------------------------------------------------------
  // load while the gated write pulse meets 2 MHz high; shifts on 4 MHz ticks
  wire precomp_parallel_load = wr_pulse && clk2; // RQ18
  wire precomp_active = precomp_en && double_density_select_out; // RQ17
  wire nominal = early_n && late_n;
  wire [2:0] load_word = !early_n ? PRECOMP_EARLY : (nominal ? PRECOMP_NOMINAL : PRECOMP_LATE);
  logic [2:0] shreg;
  logic load_seen;
  logic [7:0] stretch;
  logic wr_prev;
  wire bypass_edge = wr_pulse && !wr_prev && !precomp_active;
  wire shift_out = shreg[0] && tick4;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      shreg <= 3'h0;
      load_seen <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      wr_prev <= wr_pulse;
      if (precomp_parallel_load && precomp_active && !load_seen) begin
        shreg <= load_word; // RQ16
        load_seen <= 1'b1;
      end else if (tick4) begin
        shreg <= {1'b0, shreg[2:1]}; // RQ16
      end
      if (!wr_pulse) load_seen <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) stretch <= 8'h00;
    else if (shift_out || bypass_edge) stretch <= 8'(STRETCH_CYCLES); // RQ18
    else if (stretch != 8'h00) stretch <= stretch - 8'h01;
  end

  assign write_pulse_out = (stretch != 8'h00);

  // ---------------------------------------------------------------
  // controller register decode
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_reg
      assign controller_reg_select_out[g] = (cpu_addr_in == PORT_CMD_STATUS + 8'(g)); // RQ20
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_sel_write;
    sel_wr;
  endsequence
  property p_mask_done;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (done_en && done_req) |=> !nmi_n_out;
  endproperty
  a_mask_done: assert property (p_mask_done) else $error("done nmi missing"); // RQ1
  property p_mask_motor;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (!motor_en && !done_req) |=> nmi_n_out;
  endproperty
  a_mask_motor: assert property (p_mask_motor) else $error("unmasked nmi"); // RQ2
  property p_status;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      1'b1 |=> cpu_data_out[BIT_DONE_EN] == !$past(done_req);
  endproperty
  a_status: assert property (p_status) else $error("status bit 7 wrong"); // RQ3
  property p_oe;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      cpu_data_oe_out |-> !$past(status_rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven without strobe"); // RQ4
  property p_select;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_sel_write |=> drive_select_out == $past(data_q2[3:0]) && motor_on_out;
  endproperty
  a_select: assert property (p_select) else $error("select not latched"); // RQ5
  property p_wait_set;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_sel_write |=> !cpu_wait_n_out;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait not raised"); // RQ8
  property p_motor_clear;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (!motor_on && !sel_wr) |=> drive_select_out == 4'h0;
  endproperty
  a_motor_clear: assert property (p_motor_clear) else $error("select kept"); // RQ11
  property p_wdog_cap;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (wait_latch && stall_watchdog_expiry && !sel_wr) |=> !wait_latch;
  endproperty
  a_wdog_cap: assert property (p_wdog_cap) else $error("watchdog ignored"); // RQ13
  property p_wdog_idle;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !wait_latch |=> wdog == '0 || wait_latch;
  endproperty
  a_wdog_idle: assert property (p_wdog_idle) else $error("watchdog ran idle"); // RQ22
  property p_divisor;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_sel_write |=> separator_divisor_select_out == !$past(data_q2[BIT_DENSITY]);
  endproperty
  a_divisor: assert property (p_divisor) else $error("divisor wrong"); // RQ19
endmodule
`default_nettype wire

// >>> fdc_drive_model.sv
// drive-side model: counts write pulses that reach a selected, spinning drive
// assumes the glue block's drive outputs are seen after the bus drivers
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
  input wire logic ref_clk_in,
  input wire logic [3:0] drive_select_in,
  input wire logic motor_on_in,
  input wire logic write_pulse_in,
  output logic [7:0] pulse_count_out
);
  logic last_pulse = 1'b0;
  logic [7:0] count = 8'h00;
  logic one_hot;
  // a drive only records while exactly one select is up and the spindle turns
  assign one_hot = (drive_select_in != 4'h0) &&
    ((drive_select_in & (drive_select_in - 4'h1)) == 4'h0);
  assign pulse_count_out = count;
  always @(posedge ref_clk_in) begin
    last_pulse <= write_pulse_in;
    if (write_pulse_in && !last_pulse && one_hot && motor_on_in) begin
      count <= count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> floppy_interface_glue_logic_tb.sv
// testbench for the floppy glue: table of select writes, then hand cases
// assumes fdc_glue_pkg, fdc_glue and fdc_drive_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module floppy_interface_glue_logic_tb;
  import fdc_glue_pkg::*;
  typedef struct packed {logic [7:0] d; logic [3:0] sel; logic side; logic dens;} row_type;
  // short motor count so expiry fits in the run
  localparam int unsigned MCYC = 4000;
  logic clk = 1'b0, rst_b = 1'b0, mwr_n = 1'b1, srd_n = 1'b1, sel_n = 1'b1;
  logic done = 1'b0, breq = 1'b0, wp = 1'b0, early_n = 1'b1, late_n = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, dout, st, pulses;
  logic oe, nmi_n, wait_n, mot, side, dens, dens_n, div, refc, cclk, wpo;
  logic [3:0] dsel, rsel;
  int fails = 0, checks = 0, n, e_dly, m_dly, l_dly, w;
  time t0, tr, tf;
  row_type rows [5] = '{'{8'h01, 4'h1, 1'b0, 1'b0}, '{8'hb2, 4'h2, 1'b1, 1'b1},
    '{8'h44, 4'h4, 1'b0, 1'b0}, '{8'hc8, 4'h8, 1'b0, 1'b1}, '{8'hf1, 4'h1, 1'b1, 1'b1}};
  fdc_glue #(.MOTOR_CYCLES(MCYC)) fdc_glue_inst (.ref_clk_in(clk), .rst_b_in(rst_b),
    .cpu_addr_in(addr), .cpu_data_in(wdata), .cpu_data_out(dout), .cpu_data_oe_out(oe),
    .irq_mask_write_strobe_n_in(mwr_n), .irq_status_read_strobe_n_in(srd_n),
    .select_latch_write_strobe_n_in(sel_n), .controller_done_request_in(done),
    .controller_byte_request_in(breq), .controller_write_pulse_in(wp),
    .precomp_early_n_in(early_n), .precomp_late_n_in(late_n), .nmi_n_out(nmi_n),
    .cpu_wait_n_out(wait_n), .drive_select_out(dsel), .side_select_out(side),
    .motor_on_out(mot), .double_density_select_out(dens),
    .double_density_select_n_out(dens_n), .separator_divisor_select_out(div),
    .separator_reference_clock_out(refc), .controller_clock_out(cclk),
    .write_pulse_out(wpo), .controller_reg_select_out(rsel));
  fdc_drive_model fdc_drive_model_inst (.ref_clk_in(clk), .drive_select_in(dsel),
    .motor_on_in(mot), .write_pulse_in(wpo), .pulse_count_out(pulses));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge wpo) tr = $time;
  always @(negedge wpo) tf = $time;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  // data held well around the strobe, since the strobe is synchronised first
  task automatic wr(input logic to_select, input logic [7:0] d);
    @(posedge clk) wdata <= d;
    cyc(2);
    @(posedge clk) if (to_select) sel_n <= 1'b0; else mwr_n <= 1'b0;
    cyc(2);
    @(posedge clk) begin sel_n <= 1'b1; mwr_n <= 1'b1; end
    cyc(6);
  endtask
  task automatic rd(output logic [7:0] v);
    @(posedge clk) srd_n <= 1'b0;
    cyc(5);
    chk(oe, 1'b1);
    v = dout;
    @(posedge clk) srd_n <= 1'b1;
    cyc(5);
    chk(oe, 1'b0);
  endtask
  task automatic wait_hi();
    n = 0;
    while (wait_n !== 1'b1 && n < 1000) begin
      @(posedge clk) n++;
    end
  endtask
  // pulses start on a controller clock edge so the 2 MHz gate phase repeats
  task automatic pulse(input logic e, input logic l, output int dly, output int wid);
    @(posedge cclk);
    @(posedge clk) begin early_n <= e; late_n <= l; wp <= 1'b1; end
    t0 = $time;
    cyc(60);
    @(posedge clk) wp <= 1'b0;
    cyc(400);
    dly = int'((tr - t0) / 4);
    wid = int'((tf - tr) / 4);
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(60000);
    fails++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(4);
    chk({nmi_n, wait_n, mot, oe, dsel}, 8'hc0);
    @(posedge clk) rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) addr <= 8'hf0 + 8'(i);
      @(negedge clk) chk(rsel, (i < 4) ? 4'(1 << i) : 4'h0);
    end
    @(posedge refc) t0 = $time;
    @(posedge refc) rng(int'(($time - t0) / 4), 60, 64);
    @(posedge cclk) t0 = $time;
    @(posedge cclk) rng(int'(($time - t0) / 4), 240, 256);
    foreach (rows[i]) begin
      wr(1'b1, rows[i].d);
      chk(dsel, rows[i].sel);
      chk(side, rows[i].side);
      chk({dens, dens_n, div}, {rows[i].dens, !rows[i].dens, !rows[i].dens});
      chk({mot, wait_n}, 2'b10);
      if (rows[i].d[6]) @(posedge clk) breq <= 1'b1;
      wait_hi();
      if (rows[i].d[6]) rng(n, 0, 8);
      else rng(n, 200, 520);
      @(posedge clk) breq <= 1'b0;
    end
    wr(1'b0, 8'h40);
    cyc(3000);
    wr(1'b1, 8'h02);
    cyc(2500);
    chk(mot, 1'b1);
    cyc(1700);
    chk({mot, dsel, dens}, 6'h00);
    chk(nmi_n, 1'b0);
    rd(st);
    chk(st, 8'hbf);
    wr(1'b0, 8'h00);
    chk(nmi_n, 1'b1);
    @(posedge clk) done <= 1'b1;
    cyc(6);
    chk(nmi_n, 1'b1);
    wr(1'b0, 8'h80);
    chk(nmi_n, 1'b0);
    rd(st);
    chk(st, 8'h3f);
    @(posedge clk) done <= 1'b0;
    cyc(6);
    chk(nmi_n, 1'b1);
    wr(1'b1, 8'ha1);
    wait_hi();
    pulse(1'b0, 1'b1, e_dly, w);
    rng(w, 118, 132);
    pulse(1'b1, 1'b1, m_dly, w);
    pulse(1'b1, 1'b0, l_dly, w);
    rng(m_dly - e_dly, 50, 75);
    rng(l_dly - e_dly, 110, 140);
    wr(1'b1, 8'h21);
    pulse(1'b1, 1'b0, n, w);
    rng(n, 0, 12);
    chk(pulses, 8'h04);
    wr(1'b1, 8'h41);
    chk(wait_n, 1'b0);
    @(posedge clk) rst_b <= 1'b0;
    cyc(2);
    chk({wait_n, mot, dsel}, 6'h20);
    @(posedge clk) rst_b <= 1'b1;
    cyc(2);
    chk({nmi_n, wait_n, mot, wpo, dsel}, 8'hc0);
    results();
  end
endmodule
`default_nettype wire
